/* rtl/t1_status_consts.vh */
// Constants for the T1 status, mask and error counter block.
// Assumes byte offsets on a 32-bit APB, one register per word.
`ifndef T1_STATUS_CONSTS_VH
`define T1_STATUS_CONSTS_VH
// Register indices; byte address is four times the index
`define IDX_STATUS_TWO 8'h21
`define IDX_LCV_HIGH 8'h23
`define IDX_LCV_LOW 8'h24
`define IDX_PCV_HIGH 8'h25
`define IDX_PCV_LOW 8'h26
`define IDX_OOS_LOW 8'h27
`define IDX_MATCH_A 8'h29
`define IDX_MATCH_B 8'h2A
`define IDX_CONTROL 8'h30
`define IDX_ALARM_IN 8'h31
`define IDX_MASK_TWO 8'h6F
`define IDX_MASK_ONE 8'h7F
// Status bit positions
`define BIT_RX_MF 7
`define BIT_TX_MF 6
`define BIT_ONE_S_TICK 5
`define BIT_RX_FULL 4
`define BIT_TX_EMPTY 3
`define BIT_MATCH 2
`define BIT_ABORT 1
`define BIT_CLK_LOST 0
// Control register fields
`define CTL_EXZ 0
`define CTL_B8ZS 1
`define CTL_ESF 2
`define CTL_SIG_FRAMING 3
`define CTL_OOS_MODE 4
// Reset values
`define RST_BYTE 8'h00
// Timing
`define CLK_PERIOD_NS 10
`define MS_PER_TICK_SHORT 999
`define MS_PER_TICK_LONG 1002
`define CLK_LOST_NS 3000
`define CLK_LOST_CYCLES (`CLK_LOST_NS / `CLK_PERIOD_NS)
`define CYCLES_PER_MS (1000000 / `CLK_PERIOD_NS)
`endif

/* rtl/t1_status_mask_error_counters.v */
// Second status register, both mask registers, the three error counters
// and an APB slave for them. Assumes receive-side events arrive as one-cycle
// pulses on the system clock, except rx_sync_lost, which is a level, and rx_clock, an asynchronous pin.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "t1_status_consts.vh"

// Contract
// - rx multiframe boundary sets status bit 7
// - tx multiframe boundary sets status bit 6
// - second tick at 999, 999, 1002 ms
// - full received datalink byte sets bit 4
// - transmit datalink buffer emptied sets bit 3
// - received byte equal to match byte sets bit 2
// - eight ones in datalink set bit 1
// - rx clock stalled about 3 us sets bit 0
// - mask one gates alarm bits, 1 enables
// - mask two gates status bits, 1 enables
// - counters transferred to readable registers each second
// - counters saturate, never wrap
// - 16-bit line count at 0x23 and 0x24
// - line count: BPVs, optional excess-zero runs
// - line counter counts even when out of sync
// - path count CRC6 or framing bit errors
// - path counter halts while out of sync
// - path count nibble at 0x25, low at 0x26
// - oos mode counts out-of-sync multiframes always
// - alternate mode counts frame pattern errors in sync
// - 12-bit oos count, nibble high 0x25, low 0x27
// - active-low interrupt on enabled event
module t1_status_mask_error_counters #(
    parameter integer MS_CYCLES = `CYCLES_PER_MS,
    parameter integer LOST_CYCLES = `CLK_LOST_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Receive stream events, one-cycle pulses; rx_sync_lost is a level
    input wire rx_multiframe_tick,
    input wire tx_multiframe_tick,
    input wire rx_datalink_bit_valid,
    input wire rx_datalink_bit,
    input wire tx_datalink_empty,
    input wire bipolar_violation,
    input wire zero_subst_word,
    input wire line_zero,
    input wire crc6_error,
    input wire terminal_framing_error,
    input wire signaling_framing_error,
    input wire esf_framing_error,
    input wire rx_sync_lost,
    // Alarm levels from the first status register
    input wire [7:0] alarm_status,
    // Receive clock pin
    input wire rx_clock,
    // Outputs
    output reg int_n,
    output reg [7:0] rx_datalink_byte
);

////////////////////////////////////////////////////////////////////////
// Register map, word index on the APB, byte address four times it
//   0x21  second status, clear on read
//   0x23  line violation count, high byte
//   0x24  line violation count, low byte
//   0x25  out-of-sync nibble high, path nibble low
//   0x26  path violation count, low byte
//   0x27  out-of-sync count, low byte
//   0x29  first datalink match byte
//   0x2A  second datalink match byte
//   0x30  receive control bits
//   0x31  alarm level readback
//   0x6F  second mask, status events
//   0x7F  first mask, alarm levels
// Only the low byte of each word carries data; the upper bits read 0.
// Unmapped words answer with pslverr and read as zero.
// Writes to read-only words are dropped without an error.

////////////////////////////////////////////////////////////////////////
// Bus decode
// One decoder shared by the write path and the read mux
function [5:0] sel_of;
    input [11:0] a;
    begin
        if (a[11:2] == {2'b00, `IDX_STATUS_TWO}) sel_of = 6'd1;
        else if (a[11:2] == {2'b00, `IDX_LCV_HIGH}) sel_of = 6'd2;
        else if (a[11:2] == {2'b00, `IDX_LCV_LOW}) sel_of = 6'd3;
        else if (a[11:2] == {2'b00, `IDX_PCV_HIGH}) sel_of = 6'd4;
        else if (a[11:2] == {2'b00, `IDX_PCV_LOW}) sel_of = 6'd5;
        else if (a[11:2] == {2'b00, `IDX_OOS_LOW}) sel_of = 6'd6;
        else if (a[11:2] == {2'b00, `IDX_MATCH_A}) sel_of = 6'd7;
        else if (a[11:2] == {2'b00, `IDX_MATCH_B}) sel_of = 6'd8;
        else if (a[11:2] == {2'b00, `IDX_CONTROL}) sel_of = 6'd9;
        else if (a[11:2] == {2'b00, `IDX_ALARM_IN}) sel_of = 6'd10;
        else if (a[11:2] == {2'b00, `IDX_MASK_TWO}) sel_of = 6'd11;
        else if (a[11:2] == {2'b00, `IDX_MASK_ONE}) sel_of = 6'd12;
        else sel_of = 6'd0;
    end
endfunction

wire [5:0] sel = sel_of(paddr);
wire access = psel & penable;
wire wr = access & pwrite;
wire rd = access & ~pwrite;
assign pready = 1'b1; // Zero wait states
assign pslverr = access & (sel == 6'd0);

reg [7:0] mask_one_q;
reg [7:0] mask_two_q;
reg [7:0] match_a_q;
reg [7:0] match_b_q;
reg [4:0] control_q;

// Writable registers; read-only ones ignore writes
always @(posedge clock or posedge rst) begin
    if (rst) begin
        mask_one_q <= `RST_BYTE;
        mask_two_q <= `RST_BYTE;
        match_a_q <= `RST_BYTE;
        match_b_q <= `RST_BYTE;
        control_q <= 5'h00;
    end else if (wr) begin
        if (sel == 6'd12) mask_one_q <= pwdata[7:0];
        else if (sel == 6'd11) mask_two_q <= pwdata[7:0];
        else if (sel == 6'd7) match_a_q <= pwdata[7:0];
        else if (sel == 6'd8) match_b_q <= pwdata[7:0];
        else if (sel == 6'd9) control_q <= pwdata[4:0];
    end
end

wire exz_on = control_q[`CTL_EXZ];
wire b8zs_on = control_q[`CTL_B8ZS];
wire esf_on = control_q[`CTL_ESF];
wire sig_fe_on = control_q[`CTL_SIG_FRAMING];
wire oos_mode = control_q[`CTL_OOS_MODE];

////////////////////////////////////////////////////////////////////////
// One-second timer: ms counter, then 999/999/1002 pattern
// Long third second keeps three ticks at exactly three seconds.
// Runs from reset with no software start, so the first tick
// comes one short second after reset is released.
// MS_CYCLES is shortened in simulation to keep runs brief.
reg [31:0] ms_cnt_q;
reg [10:0] ms_in_sec_q;
reg [1:0] phase_q;
wire ms_tick = (ms_cnt_q == MS_CYCLES - 1);
wire [10:0] sec_len = (phase_q == 2'd2) ? 11'd`MS_PER_TICK_LONG : 11'd`MS_PER_TICK_SHORT;
wire sec_tick = ms_tick & (ms_in_sec_q == sec_len - 11'd1);

always @(posedge clock or posedge rst) begin
    if (rst) begin
        ms_cnt_q <= 32'h00000000;
        ms_in_sec_q <= 11'h000;
        phase_q <= 2'd0;
    end else begin
        ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
        if (sec_tick) begin
            ms_in_sec_q <= 11'h000;
            phase_q <= (phase_q == 2'd2) ? 2'd0 : phase_q + 2'd1;
        end else if (ms_tick) begin
            ms_in_sec_q <= ms_in_sec_q + 11'd1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Receive clock watch: two-flop sync, then transition timeout
// Third flop only serves the edge detect, never the first stage.
// Timeout counter stops at its limit so it cannot wrap and
// falsely clear the lost flag on a long stall.
// Sync delay adds about two cycles to the detection time.
reg rxc_s1_q;
reg rxc_s2_q;
reg rxc_s3_q;
reg [15:0] still_q;
wire rxc_edge = rxc_s2_q ^ rxc_s3_q;
wire clk_lost = (still_q >= LOST_CYCLES);

always @(posedge clock or posedge rst) begin
    if (rst) begin
        rxc_s1_q <= 1'b0;
        rxc_s2_q <= 1'b0;
        rxc_s3_q <= 1'b0;
        still_q <= 16'h0000;
    end else begin
        rxc_s1_q <= rx_clock;
        rxc_s2_q <= rxc_s1_q;
        rxc_s3_q <= rxc_s2_q;
        if (rxc_edge) still_q <= 16'h0000;
        else if (!clk_lost) still_q <= still_q + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////
// Receive datalink: LSB first shifter, full, match, abort
// Bits arrive LSB first, so each new bit enters at the top.
// Byte count is free running; the framer must not drop bits
// inside a byte or the boundaries slip for good.
// Abort counts ones across byte boundaries, not per byte.
// Full and abort are one-cycle pulses into the status latch.
reg [7:0] shift_q;
reg [2:0] bit_cnt_q;
reg [2:0] ones_q;
reg full_q;
reg abort_q;
wire [7:0] shift_d = {rx_datalink_bit, shift_q[7:1]};

always @(posedge clock or posedge rst) begin
    if (rst) begin
        shift_q <= `RST_BYTE;
        bit_cnt_q <= 3'd0;
        ones_q <= 3'd0;
        full_q <= 1'b0;
        abort_q <= 1'b0;
        rx_datalink_byte <= `RST_BYTE;
    end else begin
        full_q <= 1'b0;
        abort_q <= 1'b0;
        if (rx_datalink_bit_valid) begin
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_q + 3'd1;
            if (bit_cnt_q == 3'd7) begin
                full_q <= 1'b1;
                rx_datalink_byte <= shift_d;
            end
            if (!rx_datalink_bit) ones_q <= 3'd0;
            else if (ones_q == 3'd7) begin
                abort_q <= 1'b1;
                ones_q <= 3'd0;
            end else ones_q <= ones_q + 3'd1;
        end
    end
end

// Compare against the byte just latched, one cycle after full
reg match_q;
always @(posedge clock or posedge rst) begin
    if (rst) match_q <= 1'b0;
    else match_q <= full_q & ((rx_datalink_byte == match_a_q) | (rx_datalink_byte == match_b_q));
end

////////////////////////////////////////////////////////////////////////
// Second status register, clear on read, set wins
// An event in the read cycle survives so it is never lost;
// the host then sees it on its next read.
// Clock lost is a level and re-sets each cycle while stalled.
wire [7:0] ev;
assign ev[`BIT_RX_MF] = rx_multiframe_tick;
assign ev[`BIT_TX_MF] = tx_multiframe_tick;
assign ev[`BIT_ONE_S_TICK] = sec_tick;
assign ev[`BIT_RX_FULL] = full_q;
assign ev[`BIT_TX_EMPTY] = tx_datalink_empty;
assign ev[`BIT_MATCH] = match_q;
assign ev[`BIT_ABORT] = abort_q;
assign ev[`BIT_CLK_LOST] = clk_lost;

reg [7:0] status_q;
wire status_rd = rd & (sel == 6'd1);
always @(posedge clock or posedge rst) begin
    if (rst) status_q <= `RST_BYTE;
    else status_q <= (status_rd ? 8'h00 : status_q) | ev;
end

// Pending sources after masking, 1 in a mask enables
wire status_pending = |(status_q & mask_two_q);
wire alarm_pending = |(alarm_status & mask_one_q);

// Interrupt from both masks, registered so the pin never glitches
// Alarm levels are not latched here: they drop with their condition.
always @(posedge clock or posedge rst) begin
    if (rst) int_n <= 1'b1;
    else int_n <= ~(status_pending | alarm_pending);
end

////////////////////////////////////////////////////////////////////////
// Error accumulators
// Accumulators run through the second; the readable copies
// only change at the tick, so the host has a full second to
// read both bytes of a count without tearing.
// An event in the tick cycle itself is dropped; that is one
// event per second at most, traded for a simpler transfer.
// Only the 16-bit line count can realistically saturate.
// Out-of-sync mode counts a multiframe if sync was lost at
// any time during it, including its closing boundary.
reg [15:0] lcv_acc_q;
reg [11:0] pcv_acc_q;
reg [11:0] oos_acc_q;
reg [15:0] lcv_q;
reg [11:0] pcv_q;
reg [11:0] oos_q;
reg [4:0] zeros_q;
reg oos_seen_q;

// Zero runs: 8 with substitution, 16 without
wire [4:0] zero_limit = b8zs_on ? 5'd8 : 5'd16;
wire zero_run = exz_on & line_zero & (zeros_q == zero_limit - 5'd1);
wire lcv_ev = (bipolar_violation & ~(b8zs_on & zero_subst_word)) | zero_run;
wire pcv_ev = ~rx_sync_lost & (esf_on ? crc6_error
              : (terminal_framing_error | (sig_fe_on & signaling_framing_error)));
wire oos_ev = oos_mode ? (rx_multiframe_tick & (rx_sync_lost | oos_seen_q))
              : (~rx_sync_lost & (esf_on ? esf_framing_error : terminal_framing_error));

always @(posedge clock or posedge rst) begin
    if (rst) begin
        lcv_acc_q <= 16'h0000;
        pcv_acc_q <= 12'h000;
        oos_acc_q <= 12'h000;
        lcv_q <= 16'h0000;
        pcv_q <= 12'h000;
        oos_q <= 12'h000;
        zeros_q <= 5'd0;
        oos_seen_q <= 1'b0;
    end else begin
        if (!line_zero || zero_run) zeros_q <= 5'd0;
        else if (line_zero) zeros_q <= zeros_q + 5'd1;
        if (rx_multiframe_tick) oos_seen_q <= rx_sync_lost;
        else if (rx_sync_lost) oos_seen_q <= 1'b1;
        if (sec_tick) begin
            lcv_q <= lcv_acc_q;
            pcv_q <= pcv_acc_q;
            oos_q <= oos_acc_q;
            lcv_acc_q <= 16'h0000;
            pcv_acc_q <= 12'h000;
            oos_acc_q <= 12'h000;
        end else begin
            if (lcv_ev && lcv_acc_q != 16'hFFFF) lcv_acc_q <= lcv_acc_q + 16'h0001;
            if (pcv_ev && pcv_acc_q != 12'hFFF) pcv_acc_q <= pcv_acc_q + 12'h001;
            if (oos_ev && oos_acc_q != 12'hFFF) oos_acc_q <= oos_acc_q + 12'h001;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read mux
// Combinational and zero outside a read access, so the bus
// shows nothing stale; reading status clears it at the same edge.
// Shared address 0x25 packs both counters' high nibbles.
always @* begin
    prdata = 32'h00000000;
    if (rd) begin
        if (sel == 6'd1) prdata[7:0] = status_q;
        else if (sel == 6'd2) prdata[7:0] = lcv_q[15:8];
        else if (sel == 6'd3) prdata[7:0] = lcv_q[7:0];
        else if (sel == 6'd4) prdata[7:0] = {oos_q[11:8], pcv_q[11:8]};
        else if (sel == 6'd5) prdata[7:0] = pcv_q[7:0];
        else if (sel == 6'd6) prdata[7:0] = oos_q[7:0];
        else if (sel == 6'd7) prdata[7:0] = match_a_q;
        else if (sel == 6'd8) prdata[7:0] = match_b_q;
        else if (sel == 6'd9) prdata[4:0] = control_q;
        else if (sel == 6'd10) prdata[7:0] = alarm_status;
        else if (sel == 6'd11) prdata[7:0] = mask_two_q;
        else if (sel == 6'd12) prdata[7:0] = mask_one_q;
    end
end

endmodule // t1_status_mask_error_counters

/* verif/t1_line_partner.sv */
// Line-side partner: the recovered receive clock pin.
// Assumes the bench lowers run to model a stalled line.
`timescale 1ns/1ps
module t1_line_partner (
    // Control and clock pin
    input wire run,
    output logic rx_clock
);
    // Unrelated in phase to the system clock; frozen when stalled
    initial rx_clock = 1'b0;
    always #37 if (run) rx_clock = ~rx_clock;
endmodule // t1_line_partner

/* verif/t1_status_asserts.sv */
// Checker for the status, mask and counter block, on its top ports.
// Assumes it is bound onto the design from the testbench file.
`timescale 1ns/1ps
module t1_status_checker (
    // Clock and reset
    input wire clock,
    input wire rst,
    // APB and watched lines
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire rx_datalink_bit_valid,
    input wire rx_datalink_bit,
    input wire [7:0] alarm_status,
    input wire int_n,
    input wire [7:0] rx_datalink_byte
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic seen_q;
    wire acc = psel && penable;
    wire hit = paddr inside {12'h084, 12'h08C, 12'h090, 12'h094, 12'h098, 12'h09C, 12'h0A4, 12'h0A8,
        12'h0C0, 12'h0C4, 12'h1BC, 12'h1FC};
    // Shadow shifter; any write high in the map may touch a mask
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            seen_q <= 1'b0;
        end else begin
            if (rx_datalink_bit_valid) begin
                cnt_q <= cnt_q + 3'h1;
                sh_q <= {rx_datalink_bit, sh_q[7:1]};
            end
            if (acc && pwrite && paddr[8])
                seen_q <= 1'b1;
        end
    end
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("bus not quiet outside access");
    property p_unmapped; acc && !hit |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_upper; acc && hit |-> !pslverr && prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("mapped access bad");
    property p_byte; rx_datalink_bit_valid && cnt_q == 3'h7 |=> rx_datalink_byte == sh_q; endproperty
    a_byte: assert property (p_byte) else $error("datalink byte wrong");
    property p_hold_byte; $changed(rx_datalink_byte) |-> $past(rx_datalink_bit_valid) && $past(cnt_q) == 3'h7;
    endproperty
    a_hold_byte: assert property (p_hold_byte) else $error("datalink byte moved early");
    property p_mask; !seen_q |-> int_n; endproperty
    a_mask: assert property (p_mask) else $error("interrupt with masks clear");
    property p_latch; !int_n && !psel && $past(psel) == 1'b0 && $stable(alarm_status) |=> !int_n; endproperty
    a_latch: assert property (p_latch) else $error("interrupt dropped unread");
endmodule // t1_status_checker

/* verif/t1_status_mask_error_counters_tb.sv */
// Testbench for the status, mask and counter block.
// Assumes checker and line partner files are compiled first.
`timescale 1ns/1ps
module t1_status_mask_error_counters_tb;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dl_v = 0, dl_b = 0, sync = 0, run = 1;
    logic lz = 0, tfe = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, int_n, e, rxc;
    logic [7:0] alarm = 0, dl_byte;
    logic [5:0] evs = 0;
    int error_cnt = 0, n_checks = 0, cyc = 0, t [4];
    typedef struct {bit w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic s;} row_t;
    row_t rows [12] = '{'{0, 12'h084, 0, 0, 0}, '{0, 12'h08C, 0, 0, 0}, '{0, 12'h090, 0, 0, 0},
        '{0, 12'h094, 0, 0, 0}, '{0, 12'h098, 0, 0, 0}, '{0, 12'h09C, 0, 0, 0}, '{1, 12'h1BC, 8'hA5, 0, 0},
        '{0, 12'h1BC, 0, 8'hA5, 0}, '{1, 12'h1FC, 8'h5A, 0, 0}, '{0, 12'h1FC, 0, 8'h5A, 0},
        '{1, 12'h08C, 8'hFF, 0, 0}, '{0, 12'h088, 0, 0, 1}};
    t1_status_mask_error_counters #(.MS_CYCLES(10), .LOST_CYCLES(20)) t1_status_mask_error_counters_i (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rx_multiframe_tick(evs[5]), .tx_multiframe_tick(evs[4]), .tx_datalink_empty(evs[3]),
        .bipolar_violation(evs[2]), .crc6_error(evs[1]), .esf_framing_error(evs[0]),
        .rx_datalink_bit_valid(dl_v), .rx_datalink_bit(dl_b), .zero_subst_word(1'b0), .line_zero(lz),
        .terminal_framing_error(tfe), .signaling_framing_error(1'b0), .rx_sync_lost(sync),
        .alarm_status(alarm), .rx_clock(rxc), .int_n(int_n), .rx_datalink_byte(dl_byte));
    t1_line_partner t1_line_partner_i (.run(run), .rx_clock(rxc));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, cycle count and watchdog
    always #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    initial begin
        #1000000;
        error_cnt++;
        tally_and_finish;
    end
    task chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, want %h", $time, s, x);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(r, x);
    endtask
    // Event pulses, one cycle high with a gap so each is distinct
    task ev(input logic [5:0] m, input int n);
        repeat (n) begin
            @(posedge clock);
            evs <= m;
            @(posedge clock);
            evs <= 6'h00;
        end
    endtask
    task dl(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            dl_v <= 1;
            dl_b <= b[i];
        end
        @(posedge clock);
        dl_v <= 0;
    endtask
    // Skip past an interrupt that a just-made read already cleared
    task wait_tick(input int k);
        int n;
        n = 0;
        repeat (2) @(posedge clock);
        while (int_n !== 1'b0 && n < 12000) begin
            @(posedge clock);
            n++;
        end
        t[k] = cyc;
        rd(12'h084, 32'h20);
    endtask
    task tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        rst <= 0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) begin
                chk(r, rows[i].x);
                chk({31'h0, e}, {31'h0, rows[i].s});
            end
        end
        $display("register table done");
        apb(1, 12'h0A4, 8'h3C);
        apb(1, 12'h1BC, 8'h14);
        dl(8'h3C);
        repeat (4) @(posedge clock);
        chk({24'h0, dl_byte}, 8'h3C);
        chk({31'h0, int_n}, 0);
        rd(12'h084, 32'h14);
        rd(12'h084, 32'h00);
        dl(8'hFF);
        repeat (4) @(posedge clock);
        rd(12'h084, 32'h12);
        ev(6'h38, 1);
        rd(12'h084, 32'hC8);
        $display("status events done");
        apb(1, 12'h1FC, 8'h01);
        alarm <= 8'h01;
        repeat (3) @(posedge clock);
        chk({31'h0, int_n}, 0);
        apb(1, 12'h1FC, 8'h00);
        repeat (3) @(posedge clock);
        chk({31'h0, int_n}, 1);
        alarm <= 8'h00;
        run <= 0;
        repeat (40) @(posedge clock);
        rd(12'h084, 32'h01);
        run <= 1;
        repeat (10) @(posedge clock);
        apb(0, 12'h084, 0);
        rd(12'h084, 32'h00);
        $display("mask and clock loss done");
        apb(1, 12'h0C0, 8'h04);
        apb(1, 12'h1BC, 8'h20);
        sync <= 1;
        ev(6'h04, 5);
        ev(6'h02, 3);
        ev(6'h01, 2);
        sync <= 0;
        ev(6'h02, 2);
        ev(6'h01, 4);
        wait_tick(0);
        rd(12'h08C, 32'h00);
        rd(12'h090, 32'h05);
        rd(12'h094, 32'h00);
        rd(12'h098, 32'h02);
        rd(12'h09C, 32'h04);
        ev(6'h02, 4200);
        wait_tick(1);
        rd(12'h094, 32'h0F);
        rd(12'h098, 32'hFF);
        rd(12'h090, 32'h00);
        rd(12'h09C, 32'h00);
        apb(1, 12'h0C0, 8'h01);
        lz <= 1;
        repeat (16) @(posedge clock);
        lz <= 0;
        tfe <= 1;
        @(posedge clock);
        tfe <= 0;
        wait_tick(2);
        rd(12'h090, 32'h01);
        rd(12'h098, 32'h01);
        rd(12'h09C, 32'h01);
        wait_tick(3);
        chk(t[3] - t[0], 30000);
        $display("counters and ticks done");
        tally_and_finish;
    end
endmodule // t1_status_mask_error_counters_tb
bind t1_status_mask_error_counters t1_status_checker t1_status_checker_i (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rx_datalink_bit_valid(rx_datalink_bit_valid), .rx_datalink_bit(rx_datalink_bit),
    .alarm_status(alarm_status), .int_n(int_n), .rx_datalink_byte(rx_datalink_byte));
